// ### disk_ctrl_rate_status_regs.sv
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module disk_ctrl_rate_status_regs #(
    parameter int TRACK_W = 8
) (
    // Clock and reset.
    input  wire logic                                          i_sys_clk,
    input  wire logic                                          i_rst,
    // Register port.
    input  wire logic [disk_ctrl_rate_status_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [disk_ctrl_rate_status_pkg::DATA_W-1:0]  i_wr_data,
    input  wire logic                                          i_wr_en,
    input  wire logic                                          i_rd_en,
    output logic      [disk_ctrl_rate_status_pkg::DATA_W-1:0]  o_rd_data,
    output logic      [disk_ctrl_rate_status_pkg::DATA_W-1:0]  o_rd_data_oe,
    // Identification and mode inputs.
    input  wire logic                                          i_ext_reg_enable,
    input  wire logic [1:0]                                    i_media_id,
    input  wire logic [1:0]                                    i_drive_type_id,
    input  wire logic                                          i_double_clock_select,
    input  wire logic                                          i_rate_2m,
    input  wire logic [TRACK_W-1:0]                            i_shift_start_track,
    input  wire logic [TRACK_W-1:0]                            i_current_track,
    // Drive select and motor lines.
    input  wire logic [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] i_logical_select,
    input  wire logic [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] i_logical_motor,
    input  wire logic                                          i_output_control_reset,
    output logic      [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] o_select_pin,
    output logic      [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] o_motor_pin,
    output logic      [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] o_tape_pin,
    // Command engine status.
    input  wire logic                                          i_cmd_accepted,
    input  wire logic                                          i_result_done,
    input  wire logic                                          i_no_result_done,
    input  wire logic                                          i_exec_phase,
    input  wire logic                                          i_polled_mode,
    input  wire logic                                          i_host_request,
    input  wire logic                                          i_transfer_direction,
    input  wire logic [disk_ctrl_rate_status_pkg::NUM_DRIVES-1:0] i_drive_seek_active,
    input  wire logic                                          i_save_cmd,
    input  wire logic                                          i_restore_cmd,
    input  wire logic                                          i_restore_osc,
    // Reset, power and rate outputs.
    output logic                                               o_soft_reset,
    output logic                                               o_core_abort,
    output logic                                               o_powered_down,
    output logic                                               o_osc_power_off,
    output logic                                               o_clock_in_enable,
    output logic                                               o_saved_osc_power_off,
    output logic      [1:0]                                    o_rate_code,
    output logic                                               o_rate_tick,
    output logic                                               o_shift_enable,
    output logic      [4:0]                                    o_write_shift_units
);
    import disk_ctrl_rate_status_pkg::*;

    if (TRACK_W < 1 || TRACK_W > 16) begin : g_bad_track_w
        $error("TRACK_W must lie between 1 and 16.");
    end

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------
    // Physical pin index that carries a logical drive under a boot code.
    function automatic logic [1:0] map_drive(input logic [1:0] boot, input logic [1:0] idx);
        logic [1:0] res;
        res = idx;
        case (boot)
            BOOT_SWAP01: begin
                if (idx == 2'h0) res = 2'h1;
                else if (idx == 2'h1) res = 2'h0;
            end
            BOOT_SWAP02: begin
                if (idx == 2'h0) res = 2'h2;
                else if (idx == 2'h2) res = 2'h0;
            end
            default: res = idx;
        endcase
        return res;
    endfunction
    function automatic logic [7:0] bit_cycles(input logic fast, input logic [1:0] code);
        logic [7:0] res;
        case (code)
            RATE_1M:   res = BIT_CYC_1M;
            RATE_500K: res = BIT_CYC_500K;
            RATE_300K: res = BIT_CYC_300K;
            default:   res = BIT_CYC_250K;
        endcase
        if (fast) res = BIT_CYC_2M;
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Decoded strobes.
    // ------------------------------------------------------------------
    logic cfg_wr;
    logic rate_wr;
    logic cfg_rd;
    logic status_rd;
    assign cfg_wr    = i_wr_en && (i_addr == ADDR_DRIVE_CONFIG_EXT);
    assign rate_wr   = i_wr_en && (i_addr == ADDR_RATE_SELECT_CTRL);
    assign cfg_rd    = i_rd_en && (i_addr == ADDR_DRIVE_CONFIG_EXT);
    assign status_rd = i_rd_en && (i_addr == ADDR_MAIN_STATUS);

    // ------------------------------------------------------------------
    // Drive configuration state.
    // ------------------------------------------------------------------
    logic [1:0] boot_sel_reg;
    logic [1:0] boot_sel_next;
    logic [1:0] tape_sel_reg;
    logic [1:0] tape_sel_next;
    always_comb begin
        boot_sel_next = boot_sel_reg;
        tape_sel_next = tape_sel_reg;
        if (cfg_wr) begin
            tape_sel_next = i_wr_data[CFG_TAPE_LSB +: 2];
            if (i_ext_reg_enable) begin
                boot_sel_next = i_wr_data[CFG_BOOT_LSB +: 2];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            boot_sel_reg <= BOOT_RST;
            tape_sel_reg <= TAPE_RST;
        end else begin
            boot_sel_reg <= boot_sel_next;
            tape_sel_reg <= tape_sel_next;
        end
    end

    // ------------------------------------------------------------------
    // Rate, power and reset state.
    // ------------------------------------------------------------------
    logic [1:0] rate_code_reg;
    logic [1:0] rate_code_next;
    logic [2:0] shift_code_reg;
    logic [2:0] shift_code_next;
    logic       osc_reg;
    logic       osc_next;
    logic       saved_osc_reg;
    logic       saved_osc_next;
    logic       soft_reg;
    logic       soft_next;
    logic       abort_reg;
    logic       abort_next;
    logic       pd_reg;
    logic       pd_next;
    logic       clk_en_reg;
    logic       clk_en_next;
    always_comb begin
        rate_code_next  = rate_code_reg;
        shift_code_next = shift_code_reg;
        osc_next        = osc_reg;
        saved_osc_next  = saved_osc_reg;
        soft_next       = i_output_control_reset;
        abort_next      = 1'b0;
        pd_next         = pd_reg || abort_reg;
        if (rate_wr) begin
            rate_code_next  = i_wr_data[RATE_CODE_LSB +: 2];
            shift_code_next = i_wr_data[RATE_SHIFT_LSB +: 3];
            osc_next        = i_wr_data[RATE_OSC_BIT];
            if (i_wr_data[RATE_SWRST_BIT]) begin
                soft_next = 1'b1;
            end else if (i_wr_data[RATE_PD_BIT]) begin
                abort_next = 1'b1;
            end
        end
        if (i_restore_cmd) begin
            osc_next = osc_next && i_restore_osc;
        end
        if (i_save_cmd) begin
            saved_osc_next = osc_reg;
        end
        if (soft_next) begin
            pd_next = 1'b0;
        end
        clk_en_next = !pd_next;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rate_code_reg  <= RATE_CODE_RST;
            shift_code_reg <= SHIFT_CODE_RST;
            osc_reg        <= OSC_OFF_RST;
            saved_osc_reg  <= OSC_OFF_RST;
            soft_reg       <= 1'b0;
            abort_reg      <= 1'b0;
            pd_reg         <= 1'b0;
            clk_en_reg     <= 1'b1;
        end else begin
            rate_code_reg  <= rate_code_next;
            shift_code_reg <= shift_code_next;
            osc_reg        <= osc_next;
            saved_osc_reg  <= saved_osc_next;
            soft_reg       <= soft_next;
            abort_reg      <= abort_next;
            pd_reg         <= pd_next;
            clk_en_reg     <= clk_en_next;
        end
    end

    // ------------------------------------------------------------------
    // Command status and register reads.
    // ------------------------------------------------------------------
    logic       cmd_active_reg;
    logic       cmd_active_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic [7:0] rd_oe_reg;
    logic [7:0] rd_oe_next;
    logic [7:0] status_value;
    always_comb begin
        cmd_active_next = cmd_active_reg;
        if (i_result_done || i_no_result_done) begin
            cmd_active_next = 1'b0;
        end
        if (i_cmd_accepted) begin
            cmd_active_next = 1'b1;
        end
        if (soft_next || abort_next) begin
            cmd_active_next = 1'b0;
        end
        status_value = {i_host_request, i_transfer_direction,
                        i_polled_mode && i_exec_phase, cmd_active_reg,
                        i_drive_seek_active};
        if (pd_reg) begin
            status_value = STATUS_POWERED_DOWN;
        end
        rd_data_next = 8'h00;
        rd_oe_next   = 8'h00;
        if (cfg_rd) begin
            rd_data_next = {i_media_id, i_drive_type_id, boot_sel_reg, tape_sel_reg};
            rd_oe_next   = i_ext_reg_enable ? 8'hFF : 8'h03;
            if (!i_ext_reg_enable) begin
                rd_data_next = {6'h00, tape_sel_reg};
            end
        end else if (status_rd) begin
            rd_data_next = status_value;
            rd_oe_next   = 8'hFF;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cmd_active_reg <= 1'b0;
            rd_data_reg    <= 8'h00;
            rd_oe_reg      <= 8'h00;
        end else begin
            cmd_active_reg <= cmd_active_next;
            rd_data_reg    <= rd_data_next;
            rd_oe_reg      <= rd_oe_next;
        end
    end

    // ------------------------------------------------------------------
    // Drive pins, write shift and rate timing.
    // ------------------------------------------------------------------
    logic [3:0] sel_reg;
    logic [3:0] sel_next;
    logic [3:0] mot_reg;
    logic [3:0] mot_next;
    logic [3:0] tape_reg;
    logic [3:0] tape_next;
    logic       shift_en_reg;
    logic       shift_en_next;
    logic [4:0] units_reg;
    logic [4:0] units_next;
    logic [7:0] tick_cnt_reg;
    logic [7:0] tick_cnt_next;
    logic       tick_reg;
    logic       tick_next;
    always_comb begin
        sel_next  = 4'h0;
        mot_next  = 4'h0;
        tape_next = 4'h0;
        for (int i = 0; i < NUM_DRIVES; i++) begin
            sel_next[map_drive(boot_sel_reg, 2'(i))] = i_logical_select[i];
            mot_next[map_drive(boot_sel_reg, 2'(i))] = i_logical_motor[i];
        end
        if (tape_sel_reg != 2'h0) begin
            tape_next[map_drive(boot_sel_reg, tape_sel_reg)] = 1'b1;
        end
        if (shift_code_reg == SHIFT_DEFAULT) begin
            if (i_rate_2m) units_next = DEF_UNITS_2M;
            else if (rate_code_reg == RATE_1M) units_next = DEF_UNITS_1M;
            else units_next = DEF_UNITS_SLOW;
        end else if (i_double_clock_select) begin
            units_next = {2'h0, shift_code_reg};
        end else begin
            units_next = {1'b0, shift_code_reg, 1'b0};
        end
        shift_en_next = (shift_code_reg != SHIFT_OFF)
                        && (!i_double_clock_select || i_rate_2m)
                        && (i_current_track >= i_shift_start_track)
                        && !pd_reg;
        if (!shift_en_next) units_next = 5'h00;
        tick_next     = 1'b0;
        tick_cnt_next = tick_cnt_reg - 8'h01;
        if (tick_cnt_reg <= 8'h01) begin
            tick_next     = !pd_reg;
            tick_cnt_next = bit_cycles(i_rate_2m, rate_code_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sel_reg      <= 4'h0;
            mot_reg      <= 4'h0;
            tape_reg     <= 4'h0;
            shift_en_reg <= 1'b0;
            units_reg    <= 5'h00;
            tick_cnt_reg <= 8'h00;
            tick_reg     <= 1'b0;
        end else begin
            sel_reg      <= sel_next;
            mot_reg      <= mot_next;
            tape_reg     <= tape_next;
            shift_en_reg <= shift_en_next;
            units_reg    <= units_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    assign o_rd_data             = rd_data_reg;
    assign o_rd_data_oe          = rd_oe_reg;
    assign o_select_pin          = sel_reg;
    assign o_motor_pin           = mot_reg;
    assign o_tape_pin            = tape_reg;
    assign o_soft_reset          = soft_reg;
    assign o_core_abort          = abort_reg;
    assign o_powered_down        = pd_reg;
    assign o_osc_power_off       = osc_reg;
    assign o_clock_in_enable     = clk_en_reg;
    assign o_saved_osc_power_off = saved_osc_reg;
    assign o_rate_code           = rate_code_reg;
    assign o_rate_tick           = tick_reg;
    assign o_shift_enable        = shift_en_reg;
    assign o_write_shift_units   = units_reg;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence pd_write_s;
        rate_wr && i_wr_data[RATE_PD_BIT] && !i_wr_data[RATE_SWRST_BIT];
    endsequence
    sequence pd_enter_s;
        o_core_abort ##1 o_powered_down;
    endsequence
    sequence swrst_write_s;
        rate_wr && i_wr_data[RATE_SWRST_BIT];
    endsequence

    AST_EXT_HIDDEN: assert property (cfg_rd && !i_ext_reg_enable |=> o_rd_data_oe == 8'h03)
        else $error("Hidden config bits were driven.");
    AST_CFG_FIELDS: assert property (cfg_rd && i_ext_reg_enable |=>
        o_rd_data == {$past(i_media_id), $past(i_drive_type_id), boot_sel_reg, tape_sel_reg})
        else $error("Config read returned wrong fields.");
    AST_BOOT_KEEP: assert property (soft_reg && !cfg_wr |=> $stable(boot_sel_reg))
        else $error("Boot select changed on software reset.");
    AST_REMAP: assert property (boot_sel_reg == BOOT_SWAP02 && $stable(boot_sel_reg) |=>
        o_select_pin[2] == $past(i_logical_select[0]) && o_motor_pin[0] == $past(i_logical_motor[2]))
        else $error("Boot remap wrong.");
    AST_TAPE_NOT_BOOT: assert property ($stable(boot_sel_reg) |->
        !o_tape_pin[map_drive(boot_sel_reg, 2'h0)])
        else $error("Boot drive given tape support.");
    AST_OSC_WRITE: assert property (rate_wr && !i_restore_cmd |=> o_osc_power_off == $past(i_wr_data[RATE_OSC_BIT]))
        else $error("Oscillator bit not written.");
    AST_CLK_IN: assert property (o_clock_in_enable != o_powered_down)
        else $error("Clock input enable does not follow powerdown.");
    AST_RESTORE_NO_SET: assert property (i_restore_cmd && !osc_reg |=> !o_osc_power_off)
        else $error("Restore set the oscillator bit.");
    AST_SWRST_PULSE: assert property (swrst_write_s ##1 !i_output_control_reset && !rate_wr
        |-> o_soft_reset && !o_powered_down ##1 !o_soft_reset)
        else $error("Soft reset did not self clear.");
    AST_PD_SEQ: assert property (pd_write_s ##1 !soft_next |-> pd_enter_s)
        else $error("Powerdown sequence wrong.");
    AST_PD_STATUS: assert property (o_powered_down && status_rd |=> o_rd_data == STATUS_POWERED_DOWN)
        else $error("Status not in powerdown form.");
    AST_DOUBLE_CLK: assert property (i_double_clock_select && !i_rate_2m |=> !o_shift_enable)
        else $error("Shift active off 2 Mbps with double clock.");
    AST_SHIFT_OFF: assert property (shift_code_reg == SHIFT_OFF |=> !o_shift_enable)
        else $error("Shift code 111 did not disable.");
    AST_RATE_HOLD: assert property (soft_reg && !rate_wr |=> $stable(rate_code_reg))
        else $error("Rate changed on software reset.");
    AST_CMD_ACTIVE: assert property (i_cmd_accepted && !soft_next && !abort_next ##1 status_rd && !pd_reg
        |=> o_rd_data[4])
        else $error("Command active not shown.");
    AST_POLLED: assert property (status_rd && !pd_reg && i_polled_mode && i_exec_phase |=> o_rd_data[5])
        else $error("Polled bit not shown in execution.");
    AST_STATUS_WR: assert property (i_wr_en && i_addr == ADDR_MAIN_STATUS && !i_cmd_accepted
        && !i_result_done && !i_no_result_done && !soft_next |=> $stable(cmd_active_reg))
        else $error("Status write changed state.");

endmodule // disk_ctrl_rate_status_regs

// ### disk_ctrl_rate_status_pkg.sv
package disk_ctrl_rate_status_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int NUM_DRIVES = 4;
    localparam logic [1:0] ADDR_DRIVE_CONFIG_EXT = 2'h0;
    localparam logic [1:0] ADDR_RATE_SELECT_CTRL = 2'h1;
    localparam logic [1:0] ADDR_MAIN_STATUS = 2'h2;
    localparam int CFG_TAPE_LSB = 0;
    localparam int CFG_BOOT_LSB = 2;
    localparam int CFG_DRIVE_ID_LSB = 4;
    localparam int CFG_MEDIA_ID_LSB = 6;
    localparam int RATE_CODE_LSB = 0;
    localparam int RATE_SHIFT_LSB = 2;
    localparam int RATE_OSC_BIT = 5;
    localparam int RATE_PD_BIT = 6;
    localparam int RATE_SWRST_BIT = 7;
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] RATE_CODE_RST = RATE_250K;
    localparam logic [2:0] SHIFT_CODE_RST = 3'h0;
    localparam logic [2:0] SHIFT_OFF = 3'h7;
    localparam logic [2:0] SHIFT_DEFAULT = 3'h0;
    localparam logic [1:0] BOOT_STRAIGHT = 2'h0;
    localparam logic [1:0] BOOT_SWAP01 = 2'h1;
    localparam logic [1:0] BOOT_SWAP02 = 2'h2;
    localparam logic [1:0] BOOT_RST = 2'h0;
    localparam logic [1:0] TAPE_RST = 2'h0;
    localparam logic OSC_OFF_RST = 1'b0;
    localparam logic [4:0] DEF_UNITS_2M = 5'h01;
    localparam logic [4:0] DEF_UNITS_1M = 5'h02;
    localparam logic [4:0] DEF_UNITS_SLOW = 5'h06;
    localparam logic [7:0] STATUS_POWERED_DOWN = 8'h80;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_NS_2M = 500;
    localparam int BIT_NS_1M = 1000;
    localparam int BIT_NS_500K = 2000;
    localparam int BIT_NS_300K = 3333;
    localparam int BIT_NS_250K = 4000;
    localparam logic [7:0] BIT_CYC_2M = 8'(BIT_NS_2M / CLK_PERIOD_NS);
    localparam logic [7:0] BIT_CYC_1M = 8'(BIT_NS_1M / CLK_PERIOD_NS);
    localparam logic [7:0] BIT_CYC_500K = 8'(BIT_NS_500K / CLK_PERIOD_NS);
    localparam logic [7:0] BIT_CYC_300K = 8'(BIT_NS_300K / CLK_PERIOD_NS);
    localparam logic [7:0] BIT_CYC_250K = 8'(BIT_NS_250K / CLK_PERIOD_NS);
endpackage

// ### host_bus.sv
`timescale 1ns/10ps
module host_bus (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic [7:0] i_rd_data_oe,
    output logic      [1:0] o_addr = 2'h3,
    output logic      [7:0] o_wr_data = 8'h00,
    output logic            o_wr_en = 1'b0,
    output logic            o_rd_en = 1'b0
);
    task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic [7:0] e);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= w;
        o_rd_en <= !w;
        @(posedge i_sys_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_wr_data <= ~d;
        #1;
        q = i_rd_data;
        e = i_rd_data_oe;
    endtask
endmodule // host_bus

// ### disk_ctrl_rate_status_regs_tb.sv
`timescale 1ns/10ps
module disk_ctrl_rate_status_regs_tb;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ext_reg_enable = 1'b0, i_output_control_reset = 1'b0;
    logic i_cmd_accepted = 1'b0, i_no_result_done = 1'b0, i_exec_phase = 1'b0;
    logic i_result_done = 1'b0, i_double_clock_select = 1'b0, i_rate_2m = 1'b0;
    logic [7:0] i_shift_start_track = 8'h00, i_current_track = 8'h00;
    logic i_polled_mode = 1'b0, i_host_request = 1'b0, i_transfer_direction = 1'b0;
    logic i_save_cmd = 1'b0, i_restore_cmd = 1'b0, i_restore_osc = 1'b0;
    logic [1:0] i_media_id = 2'h2, i_drive_type_id = 2'h1;
    logic [3:0] sel = 4'h1, i_drive_seek_active = 4'h0, esel [4] = '{4'h1, 4'h2, 4'h4, 4'h1};
    logic [3:0] etape [4] = '{4'h2, 4'h1, 4'h2, 4'h2};
    logic [3:0] i_logical_motor = 4'h4;
    logic [7:0] q, e;
    int num_errors = 0, tests_run = 0;
    wire logic [1:0] i_addr, o_rate_code;
    wire logic [7:0] i_wr_data, o_rd_data, o_rd_data_oe;
    wire logic [4:0] o_write_shift_units;
    wire logic [3:0] o_select_pin, o_motor_pin, o_tape_pin;
    wire logic i_wr_en, i_rd_en, o_soft_reset, o_core_abort, o_powered_down, o_osc_power_off;
    wire logic o_clock_in_enable, o_saved_osc_power_off, o_shift_enable, o_rate_tick;
    disk_ctrl_rate_status_regs disk_ctrl_rate_status_regs_inst (.*,
        .i_logical_select(sel));
    host_bus host_bus_inst (.i_sys_clk, .i_rd_data(o_rd_data), .i_rd_data_oe(o_rd_data_oe),
        .o_addr(i_addr), .o_wr_data(i_wr_data), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en));
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        host_bus_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [1:0] a);
        host_bus_inst.xfer(1'b0, a, 8'h00, q, e);
    endtask
    task automatic tick_gap(input logic [7:0] x);
        int n = 1;
        @(negedge i_sys_clk);
        while (!o_rate_tick) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        while (!o_rate_tick) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("tick", x, 8'(n));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #200_000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(2'h0);
        chk("cfg_oe", 8'h03, e);
        i_ext_reg_enable <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            wr(2'h0, 8'(b * 4 + 1));
            rd(2'h0);
            chk("cfg", 8'(b * 4 + 8'h91), q);
            chk("sel", 8'(esel[b]), 8'(o_select_pin));
            chk("tape", 8'(etape[b]), 8'(o_tape_pin));
            chk("motor", (b == 2) ? 8'h01 : 8'h04, 8'(o_motor_pin));
        end
        for (int r = 0; r < 4; r++) begin
            wr(2'h1, 8'(r));
            rd(2'h1);
            chk("rate", 8'(r), 8'(o_rate_code));
            chk("units", (r == 3) ? 8'h02 : 8'h06, 8'(o_write_shift_units));
        end
        chk("rate_oe", 8'h00, e);
        {i_double_clock_select, i_rate_2m} <= 2'h2;
        wr(2'h1, 8'h0b);
        rd(2'h3);
        chk("shift_en", 8'h00, 8'(o_shift_enable));
        i_rate_2m <= 1'b1;
        rd(2'h3);
        chk("shift_en", 8'h01, 8'(o_shift_enable));
        chk("units", 8'h02, 8'(o_write_shift_units));
        wr(2'h1, 8'h1f);
        rd(2'h3);
        chk("shift_en", 8'h00, 8'(o_shift_enable));
        {i_double_clock_select, i_rate_2m, i_shift_start_track} <= 10'h005;
        wr(2'h1, 8'h07);
        rd(2'h3);
        chk("shift_en", 8'h00, 8'(o_shift_enable));
        i_current_track <= 8'h05;
        rd(2'h3);
        chk("units", 8'h02, 8'(o_write_shift_units));
        wr(2'h1, 8'h0f);
        wr(2'h1, 8'h8f);
        chk("soft", 8'h01, 8'(o_soft_reset));
        rd(2'h0);
        chk("cfg", 8'h9d, q);
        chk("units", 8'h06, 8'(o_write_shift_units));
        wr(2'h1, 8'h4f);
        chk("abort", 8'h01, 8'(o_core_abort));
        wr(2'h1, 8'h6f);
        rd(2'h2);
        chk("status", 8'h80, q);
        chk("clk_in", 8'h00, 8'(o_clock_in_enable));
        i_output_control_reset <= 1'b1;
        rd(2'h3);
        i_output_control_reset <= 1'b0;
        rd(2'h3);
        chk("pd", 8'h00, 8'(o_powered_down));
        chk("osc", 8'h01, 8'(o_osc_power_off));
        {i_host_request, i_transfer_direction, i_polled_mode, i_exec_phase} <= 4'hf;
        i_drive_seek_active <= 4'h5;
        i_cmd_accepted <= 1'b1;
        @(posedge i_sys_clk);
        i_cmd_accepted <= 1'b0;
        wr(2'h2, 8'h00);
        rd(2'h2);
        chk("status", 8'hf5, q);
        i_no_result_done <= 1'b1;
        i_save_cmd <= 1'b1;
        @(posedge i_sys_clk);
        i_no_result_done <= 1'b0;
        i_save_cmd <= 1'b0;
        rd(2'h2);
        chk("status", 8'he5, q);
        chk("saved", 8'h01, 8'(o_saved_osc_power_off));
        i_cmd_accepted <= 1'b1;
        @(posedge i_sys_clk);
        {i_cmd_accepted, i_result_done} <= 2'h1;
        @(posedge i_sys_clk);
        i_result_done <= 1'b0;
        rd(2'h2);
        chk("status", 8'he5, q);
        $display("register and status tests done");
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        i_restore_cmd <= 1'b1;
        i_restore_osc <= 1'b1;
        rd(2'h0);
        i_restore_cmd <= 1'b0;
        chk("cfg", 8'h90, q);
        chk("osc", 8'h00, 8'(o_osc_power_off));
        chk("rate", 8'h02, 8'(o_rate_code));
        tick_gap(8'h28);
        wr(2'h1, 8'h03);
        rd(2'h3);
        tick_gap(8'h0a);
        $display("reset and restore tests done");
        tally_and_finish();
    end
endmodule // disk_ctrl_rate_status_regs_tb
